// file: src/tbsl_crc32.sv
// byte-serial reflected crc-32 engine with a registered result
// assumes: same clock as the loader; clear and enable never together
`timescale 1ns/100ps
`default_nettype none
`include "tbsl_params.svh"

module tbsl_crc32
   import tbsl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        clr,
   input  wire logic        en,
   input  wire logic [7:0]  din,
   output logic      [31:0] crc_ff
);

   // one byte through the reflected polynomial, lsb first
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h00_0000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `TBSL_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // seeded on clear, one byte per enabled cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         crc_ff <= `TBSL_CRC_SEED;
      end else if (clr) begin
         crc_ff <= `TBSL_CRC_SEED;                      // [RL9]
      end else if (en) begin
         crc_ff <= crc_byte(crc_ff, din);               // [RL9]
      end
   end

endmodule

`default_nettype wire

// file: src/tbsl_loader.sv
// tile boot and security loader: reset delay, security word, image load, crc
// assumes: otp and flash byte reader run on mclk; ram takes one word a cycle
//
// Operation
// [RL1] tile stays in reset while the global reset is low
// [RL2] after release, wait the internal reset delay then start booting
// [RL3] security bit 5 picks otp boot, otherwise embedded flash boot
// [RL4] image is length word, length times four bytes, then crc word
// [RL5] stored crc equal to the skip value accepts the image unchecked
// [RL6] length and crc words arrive least significant byte first
// [RL7] program fills ram from lowest address; execution starts there
// [RL8] crc covers the length word and program bytes, not the crc word
// [RL9] reflected polynomial, all-ones seed, inverted residue
// [RL10] security word is read from otp before boot and drives access
// [RL11] bit 0 blocks jtag access to tile state and memory
// [RL12] bit 1 refuses link access to this tile's processor state
// [RL13] bit 5 starts from otp address 0, bypassing the boot rom
// [RL14] bit 7 enables redundant otp rows
// [RL15] bits 8 to 11 each lock programming of otp sectors 0 to 3
// [RL16] bit 12 locks all otp programming including the security word
// [RL17] bit 13 blocks jtag reads and writes of this otp
// [RL18] bit 14 disables the shared debug pin for this tile
// [RL19] bits 21 to 15 are software readable with no hardware effect
// [RL20] bits 31 to 22 extend the jtag user code
// [RL21] otp has four sectors of 512 rows of 32 bits
// [RL22] otp contents beyond the security word are copied to ram and run
// [RL23] crc mismatch without skip value flags error and never runs
`timescale 1ns/100ps
`default_nettype none
`include "tbsl_params.svh"

module tbsl_loader
   import tbsl_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    reset_n,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [31:0]             reg_rdata,
   output logic                         otp_rd_req,
   output logic                         otp_sec_sel,
   output logic      [`TBSL_OTP_AW-1:0] otp_addr,
   input  wire logic                    otp_rd_valid,
   input  wire logic [31:0]             otp_rd_data,
   output logic                         flash_req,
   input  wire logic                    flash_valid,
   input  wire logic [7:0]              flash_byte,
   output var tbsl_ram_wr_t             ram_wr,
   output logic                         core_reset_n,
   output logic                         core_run,
   output logic                         boot_error,
   output var tbsl_access_t             access
);

   localparam logic [11:0] RST_DLY = 12'(`TBSL_RST_DLY_CYC - 1);

   // ************************************************************
   // state
   // ************************************************************
   tbsl_state_t                state_ff;
   tbsl_state_t                nxt_state;
   logic [11:0]                rst_cnt_ff;
   logic [31:0]                sec_ff;
   logic                       sec_loaded_ff;
   logic                       hold_ff;
   logic [1:0]                 bidx_ff;
   logic [31:0]                asm_ff;
   logic [31:0]                words_left_ff;
   logic [`TBSL_RAM_AW-1:0]    waddr_ff;
   logic [31:0]                rx_crc_ff;
   logic                       skip_ff;
   logic [31:0]                obuf_ff;
   logic [1:0]                 ocnt_ff;
   logic                       ohave_ff;
   logic                       opend_ff;
   logic [`TBSL_OTP_AW:0]      orow_ff;
   logic [31:0]                crc_ff;

   logic                       otp_boot;
   logic                       loading;
   logic                       byte_v;
   logic [7:0]                 byte_d;
   logic                       take;
   logic                       word_done;
   logic [31:0]                word_in;
   logic                       crc_ok;
   logic                       otp_issue;
   logic                       otp_over;
   logic [`TBSL_OTP_SECTORS-1:0] sector_open;

   // ************************************************************
   // byte source selection
   // ************************************************************
   // otp boot drains otp rows byte by byte so both sources share one parser
   assign otp_boot  = sec_ff[`TBSL_SEC_SECURE_BT];                 // [RL3]
   assign loading   = (state_ff == TBSL_SIZE) || (state_ff == TBSL_PROG)
                      || (state_ff == TBSL_CRC);
   assign byte_v    = otp_boot ? ohave_ff : flash_valid;           // [RL3]
   assign byte_d    = otp_boot ? obuf_ff[7:0] : flash_byte;
   assign take      = loading && byte_v;
   assign word_done = take && (bidx_ff == 2'h3);
   assign word_in   = {byte_d, asm_ff[31:8]};                      // [RL6]
   assign crc_ok    = (~crc_ff == rx_crc_ff);                      // [RL9]
   assign otp_issue = loading && otp_boot && !ohave_ff && !opend_ff
                      && !otp_over;
   assign otp_over  = orow_ff[`TBSL_OTP_AW];                       // [RL21]

   // ************************************************************
   // sequencer
   // ************************************************************
   // next state of the boot sequence
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         TBSL_DELAY: begin
            if (rst_cnt_ff == RST_DLY) begin
               nxt_state = TBSL_SEC_REQ;                           // [RL2]
            end
         end
         TBSL_SEC_REQ: begin
            nxt_state = TBSL_SEC_WAIT;                             // [RL10]
         end
         TBSL_SEC_WAIT: begin
            if (otp_rd_valid) begin
               nxt_state = TBSL_SIZE;
            end
         end
         TBSL_SIZE: begin
            if (otp_boot && otp_over && !ohave_ff && !opend_ff) begin
               nxt_state = TBSL_ERROR;
            end else if (word_done) begin
               if (word_in == 32'h0000_0000) begin
                  nxt_state = TBSL_CRC;                            // [RL4]
               end else if (word_in > `TBSL_RAM_WORDS) begin
                  nxt_state = TBSL_ERROR;
               end else begin
                  nxt_state = TBSL_PROG;
               end
            end
         end
         TBSL_PROG: begin
            if (otp_boot && otp_over && !ohave_ff && !opend_ff) begin
               nxt_state = TBSL_ERROR;
            end else if (word_done && (words_left_ff == 32'h0000_0001)) begin
               nxt_state = TBSL_CRC;                               // [RL4]
            end
         end
         TBSL_CRC: begin
            if (otp_boot && otp_over && !ohave_ff && !opend_ff) begin
               nxt_state = TBSL_ERROR;
            end else if (word_done) begin
               nxt_state = TBSL_CHECK;
            end
         end
         TBSL_CHECK: begin
            // crc engine has taken the last program byte by now
            if (skip_ff || crc_ok) begin
               nxt_state = TBSL_RUN;                               // [RL5]
            end else begin
               nxt_state = TBSL_ERROR;                             // [RL23]
            end
         end
         TBSL_RUN: begin
            nxt_state = TBSL_RUN;
         end
         TBSL_ERROR: begin
            nxt_state = TBSL_ERROR;                                // [RL23]
         end
         default: begin
            nxt_state = TBSL_DELAY;
         end
      endcase
   end

   // state register; global reset holds everything in the delay state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= TBSL_DELAY;                                   // [RL1]
      end else begin
         state_ff <= nxt_state;
      end
   end

   // internal reset delay counter
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_cnt_ff <= 12'h000;
      end else if (state_ff == TBSL_DELAY) begin
         rst_cnt_ff <= rst_cnt_ff + 12'h001;                       // [RL2]
      end
   end

   // ************************************************************
   // security word
   // ************************************************************
   // captured once after each global reset release; reads as zero until otp answers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sec_ff        <= `TBSL_SEC_RESET;
         sec_loaded_ff <= 1'b0;
      end else if ((state_ff == TBSL_SEC_WAIT) && otp_rd_valid) begin
         sec_ff        <= otp_rd_data;                             // [RL10]
         sec_loaded_ff <= 1'b1;
      end
   end

   // access gates stay closed until the security word is known
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         access <= '0;
      end else begin
         access.jtag_en          <= sec_loaded_ff && !sec_ff[`TBSL_SEC_JTAG_OFF];  // [RL11]
         access.link_en          <= sec_loaded_ff && !sec_ff[`TBSL_SEC_LINK_OFF];  // [RL12]
         access.debug_pin_en     <= sec_loaded_ff && !sec_ff[`TBSL_SEC_DEBUG_OFF]; // [RL18]
         access.otp_jtag_en      <= sec_loaded_ff && !sec_ff[`TBSL_SEC_JTAG_OTP];  // [RL17]
         access.redund_en        <= sec_loaded_ff && sec_ff[`TBSL_SEC_REDUND];     // [RL14]
         access.prog_sec_word_en <= sec_loaded_ff && !sec_ff[`TBSL_SEC_MASTER];    // [RL16]
         access.usercode_ext     <= sec_ff[`TBSL_SEC_UEXT_HI:`TBSL_SEC_UEXT_LO];   // [RL20]
         access.prog_sector_en   <= sector_open;                                    // [RL15]
      end
   end

   // per sector lock, master lock over all; registered with the other gates above
   for (genvar g = 0; g < `TBSL_OTP_SECTORS; g++) begin : g_lock
      assign sector_open[g] = sec_loaded_ff && !sec_ff[`TBSL_SEC_LOCK_LO + g]   // [RL15]
                              && !sec_ff[`TBSL_SEC_MASTER];                      // [RL16]
   end

   // ************************************************************
   // otp reader
   // ************************************************************
   // one outstanding read; boot rows follow the security word from row 0
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         otp_rd_req  <= 1'b0;
         otp_sec_sel <= 1'b0;
         otp_addr    <= '0;
         orow_ff     <= '0;
         opend_ff    <= 1'b0;
      end else begin
         otp_rd_req  <= (state_ff == TBSL_SEC_REQ) || otp_issue;
         otp_sec_sel <= (state_ff == TBSL_SEC_REQ);                // [RL10]
         if (otp_issue) begin
            otp_addr <= orow_ff[`TBSL_OTP_AW-1:0];                // [RL13]
            orow_ff  <= orow_ff + 1'b1;                            // [RL22]
            opend_ff <= 1'b1;
         end else if (otp_rd_valid && loading) begin
            opend_ff <= 1'b0;
         end
      end
   end

   // row buffer split into bytes, least significant first
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         obuf_ff  <= 32'h0000_0000;
         ocnt_ff  <= 2'h0;
         ohave_ff <= 1'b0;
      end else if (otp_rd_valid && loading && opend_ff) begin
         obuf_ff  <= otp_rd_data;
         ocnt_ff  <= 2'h0;
         ohave_ff <= 1'b1;
      end else if (take && otp_boot) begin
         obuf_ff  <= {8'h00, obuf_ff[31:8]};                       // [RL6]
         ocnt_ff  <= ocnt_ff + 2'h1;
         ohave_ff <= (ocnt_ff != 2'h3);
      end
   end

   // flash streams only in flash boot; on entry the arriving security word decides
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flash_req <= 1'b0;
      end else begin
         flash_req <= (nxt_state == TBSL_SIZE || nxt_state == TBSL_PROG || nxt_state == TBSL_CRC)
                && !(state_ff == TBSL_SEC_WAIT ? otp_rd_data[`TBSL_SEC_SECURE_BT] : otp_boot);
      end
   end

   // ************************************************************
   // image parser
   // ************************************************************
   // word assembly, least significant byte first
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bidx_ff <= 2'h0;
         asm_ff  <= 32'h0000_0000;
      end else if (take) begin
         bidx_ff <= bidx_ff + 2'h1;
         asm_ff  <= word_in;                                       // [RL6]
      end
   end

   // word count, ram address and stored crc
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         words_left_ff <= 32'h0000_0000;
         waddr_ff      <= `TBSL_RAM_BASE;
         rx_crc_ff     <= 32'h0000_0000;
         skip_ff       <= 1'b0;
      end else if (word_done) begin
         case (state_ff)
            TBSL_SIZE: begin
               words_left_ff <= word_in;                           // [RL4]
               waddr_ff      <= `TBSL_RAM_BASE;                    // [RL7]
            end
            TBSL_PROG: begin
               words_left_ff <= words_left_ff - 32'h0000_0001;
               waddr_ff      <= waddr_ff + 1'b1;
            end
            TBSL_CRC: begin
               rx_crc_ff <= word_in;
               skip_ff   <= (word_in == `TBSL_CRC_SKIP);           // [RL5]
            end
            default: begin
               skip_ff <= skip_ff;
            end
         endcase
      end
   end

   // program words into ram from the lowest address
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ram_wr <= '0;
      end else begin
         ram_wr.we   <= word_done && (state_ff == TBSL_PROG);      // [RL7]
         ram_wr.addr <= waddr_ff;
         ram_wr.data <= word_in;
      end
   end

   // crc over length and program bytes only; crc word bytes are not fed
   tbsl_crc32 u_crc (
      .mclk    (mclk),
      .reset_n (reset_n),
      .clr     (state_ff == TBSL_SEC_REQ),
      .en      (take && (state_ff != TBSL_CRC)),                   // [RL8]
      .din     (byte_d),
      .crc_ff  (crc_ff)
   );

   // ************************************************************
   // tile control outputs
   // ************************************************************
   // tile leaves reset only on an accepted image, pc at the ram base
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         core_reset_n <= 1'b0;                                     // [RL1]
         core_run     <= 1'b0;
         boot_error   <= 1'b0;
      end else begin
         core_reset_n <= (state_ff == TBSL_RUN) && !hold_ff;       // [RL7]
         core_run     <= (state_ff == TBSL_RUN);
         boot_error   <= (state_ff == TBSL_ERROR);                 // [RL23]
      end
   end

   // ************************************************************
   // register port
   // ************************************************************
   // control: hold bit keeps the tile in reset after a good load
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         hold_ff <= `TBSL_CTL_RESET;
      end else if (reg_wr && (reg_addr == `TBSL_OFS_CONTROL)) begin
         hold_ff <= reg_wdata[`TBSL_CTL_HOLD];
      end
   end

   // read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `TBSL_OFS_SECURITY: begin
               reg_rdata <= sec_ff;                                // [RL19]
            end
            `TBSL_OFS_STATUS: begin
               reg_rdata                       <= 32'h0000_0000;
               reg_rdata[`TBSL_ST_SEC_LOADED]  <= sec_loaded_ff;
               reg_rdata[`TBSL_ST_LOADING]     <= loading;
               reg_rdata[`TBSL_ST_RUN]         <= (state_ff == TBSL_RUN);
               reg_rdata[`TBSL_ST_ERROR]       <= (state_ff == TBSL_ERROR);
               reg_rdata[`TBSL_ST_OTP_BOOT]    <= otp_boot;
               reg_rdata[`TBSL_ST_CRC_SKIP]    <= skip_ff;
            end
            `TBSL_OFS_CONTROL: begin
               reg_rdata <= {31'h0000_0000, hold_ff};
            end
            `TBSL_OFS_CRC: begin
               reg_rdata <= ~crc_ff;                               // [RL9]
            end
            default: begin
               reg_rdata <= 32'h0000_0000;
            end
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

// file: src/tbsl_params.svh
// constants of the tile boot and security loader: offsets, bit fields, timing
// assumes: included by bare name from the package and the loader
`ifndef TBSL_PARAMS_SVH
`define TBSL_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define TBSL_OFS_SECURITY   8'h00
`define TBSL_OFS_STATUS     8'h04
`define TBSL_OFS_CONTROL    8'h08
`define TBSL_OFS_CRC        8'h0c

// ************************************************************
// security word fields
// ************************************************************
`define TBSL_SEC_JTAG_OFF   0
`define TBSL_SEC_LINK_OFF   1
`define TBSL_SEC_SECURE_BT  5
`define TBSL_SEC_REDUND     7
`define TBSL_SEC_LOCK_LO    8
`define TBSL_SEC_MASTER     12
`define TBSL_SEC_JTAG_OTP   13
`define TBSL_SEC_DEBUG_OFF  14
`define TBSL_SEC_GP_HI      21
`define TBSL_SEC_GP_LO      15
`define TBSL_SEC_UEXT_HI    31
`define TBSL_SEC_UEXT_LO    22
`define TBSL_SEC_RESET      32'h0000_0000

// ************************************************************
// status and control fields
// ************************************************************
`define TBSL_ST_SEC_LOADED  0
`define TBSL_ST_LOADING     1
`define TBSL_ST_RUN         2
`define TBSL_ST_ERROR       3
`define TBSL_ST_OTP_BOOT    4
`define TBSL_ST_CRC_SKIP    5
`define TBSL_CTL_HOLD       0
`define TBSL_CTL_RESET      1'b0

// ************************************************************
// image, crc and otp geometry
// ************************************************************
`define TBSL_CRC_POLY       32'hedb8_8320
`define TBSL_CRC_SEED       32'hffff_ffff
`define TBSL_CRC_SKIP       32'h0d15_ab1e
`define TBSL_RAM_AW         16
`define TBSL_RAM_WORDS      32'h0001_0000
`define TBSL_RAM_BASE       16'h0000
`define TBSL_OTP_SECTORS    4
`define TBSL_OTP_ROWS       512
`define TBSL_OTP_AW         11

// ************************************************************
// timing
// ************************************************************
`define TBSL_CLK_PERIOD_NS  10
`define TBSL_RST_DLY_NS     15000
`define TBSL_RST_DLY_CYC    \
   ((`TBSL_RST_DLY_NS + `TBSL_CLK_PERIOD_NS - 1) / `TBSL_CLK_PERIOD_NS)

`endif

// file: src/tbsl_pkg.sv
// types shared by the loader and its crc engine
// assumes: tbsl_params.svh is on the include path
`include "tbsl_params.svh"

package tbsl_pkg;

   // boot sequencer states
   typedef enum logic [3:0] {
      TBSL_DELAY,
      TBSL_SEC_REQ,
      TBSL_SEC_WAIT,
      TBSL_SIZE,
      TBSL_PROG,
      TBSL_CRC,
      TBSL_CHECK,
      TBSL_RUN,
      TBSL_ERROR
   } tbsl_state_t;

   // one word write into tile ram
   typedef struct packed {
      logic                      we;
      logic [`TBSL_RAM_AW-1:0]   addr;
      logic [31:0]               data;
   } tbsl_ram_wr_t;

   // access controls derived from the security word
   typedef struct packed {
      logic                          jtag_en;
      logic                          link_en;
      logic                          debug_pin_en;
      logic                          otp_jtag_en;
      logic                          redund_en;
      logic [`TBSL_OTP_SECTORS-1:0]  prog_sector_en;
      logic                          prog_sec_word_en;
      logic [9:0]                    usercode_ext;
   } tbsl_access_t;

endpackage

// file: verification/tbsl_far_model.sv
// otp and embedded flash model
// assumes bench gives security word and 3-word image
`timescale 1ns/100ps
`default_nettype none
module tbsl_far_model (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        otp_rd_req,
   input  wire logic        otp_sec_sel,
   input  wire logic [10:0] otp_addr,
   input  wire logic        flash_req,
   input  wire logic [31:0] sec_word,
   input  wire logic [95:0] img,
   output logic             otp_rd_valid,
   output logic      [31:0] otp_rd_data,
   output logic             flash_valid,
   output logic      [7:0]  flash_byte
);
   logic [3:0] idx_ff;
   // otp answers a cycle late; idle data churns so stale words show
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         otp_rd_valid <= 1'b0;
         otp_rd_data  <= 32'h0;
      end else begin
         otp_rd_valid <= otp_rd_req;
         otp_rd_data  <= !otp_rd_req ? ~otp_rd_data
            : otp_sec_sel ? sec_word : img[{otp_addr[1:0], 5'h0} +: 32];
      end
   end
   // flash byte every other cycle, lsb first, only while asked
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         idx_ff      <= 4'h0;
         flash_valid <= 1'b0;
         flash_byte  <= 8'h0;
      end else if (flash_req && !flash_valid && idx_ff < 4'hc) begin
         idx_ff      <= idx_ff + 4'h1;
         flash_valid <= 1'b1;
         flash_byte  <= img[{idx_ff, 3'h0} +: 8];
      end else begin
         flash_valid <= 1'b0;
         flash_byte  <= ~flash_byte;
      end
   end
endmodule
`default_nettype wire

// file: verification/tbsl_loader_props.sv
// loader port checker
// assumes one clock mclk and reset_n
`timescale 1ns/100ps
`default_nettype none
// ***
// checker
// ***
module tbsl_loader_props
   import tbsl_pkg::*;
(
   input wire logic         mclk,
   input wire logic         reset_n,
   input wire logic         reg_rd,
   input wire logic [31:0]  reg_rdata,
   input wire logic         otp_rd_req,
   input wire logic         otp_sec_sel,
   input wire logic         flash_req,
   input wire tbsl_ram_wr_t ram_wr,
   input wire logic         core_reset_n,
   input wire logic         core_run,
   input wire logic         boot_error,
   input wire tbsl_access_t access
);
   logic [15:0] cyc_ff;
   logic [15:0] wcnt_ff;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // cycles since release saturate, so a late boot cannot wrap
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cyc_ff  <= 16'h0;
         wcnt_ff <= 16'h0;
      end else begin
         cyc_ff  <= cyc_ff + {15'h0, cyc_ff != 16'hffff};
         wcnt_ff <= wcnt_ff + {15'h0, ram_wr.we};
      end
   end
   rst_hold_a: assert property (!$past(reset_n) |-> !core_reset_n)
      else $error("tile left reset");
   sec_delay_a: assert property (otp_rd_req && otp_sec_sel |-> cyc_ff inside {[1500:1505]})
      else $error("boot delay wrong");
   ram_addr_a: assert property (ram_wr.we |-> ram_wr.addr == wcnt_ff)
      else $error("ram address wrong");
   we_space_a: assert property (ram_wr.we |=> !ram_wr.we [*3])
      else $error("ram writes too close");
   run_err_a: assert property (boot_error |-> !core_run && !core_reset_n)
      else $error("ran after error");
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not idle");
   lock_all_a: assert property (!access.prog_sec_word_en |-> access.prog_sector_en == 4'h0)
      else $error("sector open under lock");
   boot_src_a: assert property (flash_req |-> !otp_rd_req)
      else $error("two boot sources");
   cover property ($rose(core_run));
   cover property ($rose(boot_error));
   cover property (ram_wr.we);
endmodule
bind tbsl_loader tbsl_loader_props tbsl_loader_props_i (.mclk(mclk), .reset_n(reset_n),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_rd_req(otp_rd_req), .otp_sec_sel(otp_sec_sel),
   .flash_req(flash_req), .ram_wr(ram_wr), .core_reset_n(core_reset_n), .core_run(core_run),
   .boot_error(boot_error), .access(access));
`default_nettype wire

// file: verification/test_tbsl_loader.sv
// bench: flash, otp and bad-crc boots with register checks
// assumes far model answers otp and flash
`timescale 1ns/100ps
`default_nettype none
module test_tbsl_loader;
   import tbsl_pkg::*;
   logic         mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]   reg_addr = 8'h0, flash_byte;
   logic [31:0]  reg_wdata = 32'h0, rnd = 32'h53, sec_word = 32'h0, reg_rdata, otp_rd_data;
   logic [95:0]  img = 96'h0;
   logic [10:0]  otp_addr;
   logic         otp_rd_req, otp_sec_sel, otp_rd_valid, flash_req, flash_valid;
   logic         core_reset_n, core_run, boot_error;
   tbsl_ram_wr_t ram_wr;
   tbsl_access_t access;
   logic [47:0]  exp_q[$];
   int           bad_count = 0, checked = 0;
   always #5 mclk = ~mclk;
   tbsl_loader tbsl_loader_i (.*);
   tbsl_far_model tbsl_far_model_i (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one register cycle; read data is settled just after the next edge
   task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
      @(posedge mclk);
      {reg_wr, reg_rd} <= 2'b00;
      #1;
   endtask
   // ram writes are compared against the oldest queued note
   always @(posedge mclk)
      if (ram_wr.we === 1'b1) chk("ram", exp_q.pop_front(), ram_wr[47:0]);
   task automatic boot(input logic [31:0] s, input logic [31:0] crc, input logic err);
      int n;
      @(posedge mclk);
      rnd = lfsr(rnd);
      {reset_n, sec_word, img} <= {1'b0, s, crc, rnd, 32'h1};
      exp_q.push_back({16'h0, rnd});
      repeat (16) @(posedge mclk);
      chk("held", 0, {core_reset_n, access});
      reset_n <= 1'b1;
      for (n = 0; n < 3000 && core_run !== 1'b1 && boot_error !== 1'b1; n++) @(posedge mclk);
      if (n == 3000) chk("timeout", 1, 0);
      if (n == 3000) stop_test();
      repeat (4) @(posedge mclk);
      chk("done", {!err, !err, err, 1'b1},
          {core_reset_n, core_run, boot_error, exp_q.size() == 0});
      chk("access", {~s[0], ~s[1], ~s[14], ~s[13], s[7], ~s[11:8] & {4{~s[12]}}, ~s[12],
          s[31:22]}, access);
      rw(1'b0, 8'h04, 32'h0);
      chk("status", {crc == 32'h0d15_ab1e, s[5], err, !err}, reg_rdata[5:2]);
   endtask
   initial begin
      boot(lfsr(rnd) & ~32'h20, 32'h0d15_ab1e, 1'b0);
      rw(1'b1, 8'h00, 32'hffff_ffff);
      rw(1'b0, 8'h00, 32'h0);
      chk("security", sec_word, reg_rdata);
      rw(1'b1, 8'h08, 32'h1);
      rw(1'b0, 8'h08, 32'h0);
      chk("control", 1, reg_rdata);
      rw(1'b0, 8'h10, 32'h0);
      chk("unmapped", 0, {core_reset_n, reg_rdata});
      boot(rnd | 32'h20, 32'h0d15_ab1e, 1'b0);
      boot(rnd & ~32'h20, 32'h0, 1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
